// >>> hdl/fault_status_pkg.sv
// Package with constants for the driver fault status bank
package fault_status_pkg;

	// Serial frame layout
	localparam int FRAME_BITS = 24;
	localparam logic [4:0] FRAME_BITS_CNT = 5'h18;
	localparam logic [4:0] ADDR_DONE_CNT = 5'h08;
	localparam logic [4:0] COUNT_MAX = 5'h1F;
	localparam int READ_FLAG_POS = 22;
	localparam int ADDR_WIDTH = 6;
	localparam logic [1:0] STATUS_LEAD = 2'h3;

	// Register offsets
	localparam logic [5:0] OFS_SUMMARY_ONE = 6'h00;
	localparam logic [5:0] OFS_SUMMARY_TWO = 6'h01;
	localparam logic [5:0] OFS_BRIDGE_OC = 6'h03;
	localparam logic [5:0] OFS_BRIDGE_OL = 6'h04;
	localparam logic [5:0] OFS_GLASS_HEAT = 6'h05;
	localparam logic [5:0] OFS_HIGH_SIDE = 6'h06;
	localparam logic [5:0] OFS_HIGH_TRIP = 6'h07;

	// Reset values
	localparam logic [15:0] RST_SUMMARY_ONE = 16'hC000;
	localparam logic [15:0] RST_STATUS = 16'h0000;
	localparam logic [15:0] READ_ZERO = 16'h0000;

	// Bits held until the clear-fault command; the rest follow the detectors
	localparam logic [15:0] STICKY_ONE = 16'h00ED;
	localparam logic [15:0] STICKY_TWO = 16'hAF00;
	localparam logic [15:0] STICKY_BRIDGE_OC = 16'h3F3F;
	localparam logic [15:0] STICKY_BRIDGE_OL = 16'h0FFF;
	localparam logic [15:0] STICKY_GLASS_HEAT = 16'h7F00;
	localparam logic [15:0] STICKY_HIGH_SIDE = 16'h3F3F;
	localparam logic [15:0] STICKY_HIGH_TRIP = 16'h0040;

	// Summary bit positions
	localparam int POS_LINK_OK = 15;
	localparam int POS_POWER_ON = 14;
	localparam int POS_FAULT = 13;
	localparam int POS_WARN = 12;
	localparam int POS_BRIDGE_SUM = 10;
	localparam int POS_GLASS_SUM = 9;
	localparam int POS_HIGH_SUM = 8;

	// Fault and warning bits of the summary, glass and trip words (own flags only)
	localparam logic [15:0] FAULT_ONE = 16'h00ED;
	localparam logic [15:0] WARN_ONE = 16'h0012;
	localparam logic [15:0] WARN_TWO = 16'h00FF;
	localparam logic [15:0] WARN_GLASS_HEAT = 16'h007F;
	localparam logic [15:0] FAULT_GLASS_HEAT = 16'h7F00;
	localparam logic [15:0] WARN_HIGH_TRIP = 16'h005F;

	// Glass diagnostic selection codes
	localparam logic [1:0] DIAG_SHORT = 2'h1;
	localparam logic [1:0] DIAG_OFF_OPEN = 2'h2;

	// Serial receive states
	typedef enum logic [1:0] {
		LINK_IDLE,
		LINK_FRAME
	} link_state_t;

endpackage

// >>> hdl/driver_fault_status_bank.sv
// Read-only fault and warning status bank reached over the serial link
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Link-ok bit 15 drops after clock-count fault
// - Power-on bit 14 set on detection, resets 1
// - Bit 13 is OR of all faults
// - Bit 12 set while any warning present
// - Bit 10 ORs bridge overcurrent, active open load
// - Bit 9 ORs glass and heater faults
// - Bit 8 ORs high-side driver faults
// - Supply and pump voltage flags in bits 7,6,5,0
// - Thermal, watchdog, trip flags in bits 4-1
// - Second summary bit 15 flags memory error
// - Frame without exactly 24 clocks sets bit 13
// - Zone shutdowns in bits 11 to 8
// - Zone hot warnings in bits 7 to 4
// - Zone warm warnings in bits 3 to 0
// - Bridge overcurrent low 13-8, high 5-0
// - Bridge off-state open load in bit 12
// - Bridge active open load low 11-6, high 5-0
// - Bit 15 shows diagnostic chosen by selection
// - Glass feedback faults in bits 14 to 10
// - Heater open load bit 9, drain-source bit 8
// - Output trip warnings 7..1 in bits 6-0
// - High-side open load 13-8, overcurrent 5-0
// - Reserved bits zero; documented reset values
// - Discharge trip flag held until clear command
// - Read returns status byte then register data
module driver_fault_status_bank
	import fault_status_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// Serial link pins
	input wire logic sclk,
	input wire logic chipSelectN,
	input wire logic sdi,
	output logic sdo,
	output logic sdoEn,
	// Device level detectors
	input wire logic porDetected,
	input wire logic otpError,
	input wire logic supply_undervoltage,
	input wire logic supply_overvoltage_low_level,
	input wire logic supply_overvoltage_high_level,
	input wire logic pump_undervoltage,
	input wire logic watchdog_fault,
	input wire logic [3:0] zone_thermal_shutdown,
	input wire logic [3:0] zone_hot_warning,
	input wire logic [3:0] zone_warm_warning,
	// Half-bridge detectors, index 0 is bridge one
	input wire logic [5:0] bridge_low_overcurrent,
	input wire logic [5:0] bridge_high_overcurrent,
	input wire logic bridge_offstate_open_load,
	input wire logic [5:0] bridge_low_active_open_load,
	input wire logic [5:0] bridge_high_active_open_load,
	// Glass and heater detectors
	input wire logic [1:0] glass_diag_select,
	input wire logic glassShortFault,
	input wire logic glassOffOpenLoad,
	input wire logic glass_battery_short,
	input wire logic glass_regulation_high,
	input wire logic glass_regulation_low,
	input wire logic glass_overcurrent,
	input wire logic glass_open_load,
	input wire logic heater_open_load,
	input wire logic heater_drain_source_fault,
	input wire logic glassDischargeTrip,
	// Output trip warnings, index 0 is output one
	input wire logic [11:0] output_trip_warning,
	// High-side detectors, index 0 is output seven
	input wire logic [5:0] high_side_open_load,
	input wire logic [5:0] high_side_overcurrent,
	// Clear-fault command pulse
	input wire logic clear_faults_command
);

	// Stored register words
	logic [15:0] summaryOne;
	logic [15:0] summaryTwo;
	logic [15:0] bridgeOc;
	logic [15:0] bridgeOl;
	logic [15:0] glassHeat;
	logic [15:0] highSide;
	logic [15:0] highTrip;

	// Raw detector words
	logic [15:0] rawOne;
	logic [15:0] rawTwo;
	logic [15:0] rawBridgeOc;
	logic [15:0] rawBridgeOl;
	logic [15:0] rawGlassHeat;
	logic [15:0] rawHighSide;
	logic [15:0] rawHighTrip;

	// Derived summary indications
	logic anyFault;
	logic anyWarn;
	logic bridgeSum;
	logic glassSum;
	logic highSum;
	logic voltageSum;

	// Serial link state
	link_state_t linkState;
	logic sclkPrev;
	logic csPrev;
	logic [4:0] bitCount;
	logic [7:0] rxCommand;
	logic [23:0] txShift;
	logic countFaultEvent;
	logic frameStart;
	logic frameEnd;
	logic sclkRise;
	logic sclkFall;
	logic [4:0] next_bitCount;

	// Sticky bits keep their value until a clear; a new event beats the clear
	function automatic logic [15:0] updateWord(
		input logic [15:0] cur,
		input logic [15:0] raw,
		input logic [15:0] sticky,
		input logic clr
	);
		logic [15:0] held;
		held = clr ? READ_ZERO : cur;
		updateWord = ((held | raw) & sticky) | (raw & ~sticky);
	endfunction

	// Register read decode; unmapped and reserved offsets read zero
	function automatic logic [15:0] readWord(input logic [ADDR_WIDTH-1:0] addr);
		case (addr)
			OFS_SUMMARY_ONE: readWord = summaryOne;
			OFS_SUMMARY_TWO: readWord = summaryTwo;
			OFS_BRIDGE_OC: readWord = bridgeOc;
			OFS_BRIDGE_OL: readWord = bridgeOl;
			OFS_GLASS_HEAT: readWord = glassHeat;
			OFS_HIGH_SIDE: readWord = highSide;
			OFS_HIGH_TRIP: readWord = highTrip;
			// Offsets two, eight and above hold nothing in this bank
			default: readWord = READ_ZERO;
		endcase
	endfunction

	// Assemble the raw detector words at their bit positions
	always_comb begin
		// First summary word: voltage, thermal, watchdog and trip flags
		rawOne = {8'h00, supply_undervoltage, supply_overvoltage_low_level,
			pump_undervoltage, |{zone_hot_warning, zone_warm_warning},
			|zone_thermal_shutdown, watchdog_fault,
			|{output_trip_warning, glassDischargeTrip},
			supply_overvoltage_high_level};
		// Second summary word: memory, frame and zone flags
		rawTwo = {otpError, 1'b0, countFaultEvent, 1'b0,
			zone_thermal_shutdown, zone_hot_warning, zone_warm_warning};
		// Bridge words keep their reserved gaps at zero
		rawBridgeOc = {2'h0, bridge_low_overcurrent, 2'h0, bridge_high_overcurrent};
		rawBridgeOl = {3'h0, bridge_offstate_open_load,
			bridge_low_active_open_load, bridge_high_active_open_load};
		// Start from zero so that reserved bit 7 reads zero
		rawGlassHeat = READ_ZERO;
		// Result bit shows whichever diagnostic the selection picks
		if (glass_diag_select == DIAG_SHORT) begin
			rawGlassHeat[15] = glassShortFault;
		end else if (glass_diag_select == DIAG_OFF_OPEN) begin
			rawGlassHeat[15] = glassOffOpenLoad;
		end else begin
			rawGlassHeat[15] = 1'b0;
		end
		rawGlassHeat[14:10] = {glass_battery_short, glass_regulation_high,
			glass_regulation_low, glass_overcurrent, glass_open_load};
		rawGlassHeat[9:8] = {heater_open_load, heater_drain_source_fault};
		rawGlassHeat[6:0] = output_trip_warning[6:0];
		// High-side fault word and trip word
		rawHighSide = {2'h0, high_side_open_load, 2'h0, high_side_overcurrent};
		rawHighTrip = {9'h000, glassDischargeTrip, 1'b0, output_trip_warning[11:7]};
	end

	// Summary ORs over the stored words
	always_comb begin
		bridgeSum = |{bridgeOc, bridgeOl[11:0]};
		glassSum = |glassHeat[14:8];
		highSum = |highSide;
		anyFault = |{summaryOne & FAULT_ONE, summaryTwo & STICKY_TWO,
			bridgeSum, glassSum, highSum};
		anyWarn = |{summaryOne & WARN_ONE, summaryTwo & WARN_TWO,
			glassHeat & WARN_GLASS_HEAT, highTrip & WARN_HIGH_TRIP};
		voltageSum = |{summaryOne[7:5], summaryOne[0]};
	end

	// First summary word: flags, derived summaries, link and power-on bits
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			summaryOne <= RST_SUMMARY_ONE;
		end else begin
			// Sticky flags and live warnings from the detectors
			summaryOne <= updateWord(summaryOne, rawOne, STICKY_ONE, clear_faults_command);
			// Reserved bit always reads zero
			summaryOne[11] <= 1'b0;
			// Summary bits follow the stored words one cycle later
			summaryOne[POS_FAULT] <= anyFault;
			summaryOne[POS_WARN] <= anyWarn;
			summaryOne[POS_BRIDGE_SUM] <= bridgeSum;
			summaryOne[POS_GLASS_SUM] <= glassSum;
			summaryOne[POS_HIGH_SUM] <= highSum;
			// A fault on this clock beats a clear on the same clock
			if (countFaultEvent) begin
				summaryOne[POS_LINK_OK] <= 1'b0;
			end else if (clear_faults_command) begin
				summaryOne[POS_LINK_OK] <= 1'b1;
			end else begin
				// No event: the word update above must not drop the flag
				summaryOne[POS_LINK_OK] <= summaryOne[POS_LINK_OK];
			end
			// Power-on flag is set by detection and dropped by a clear
			if (porDetected) begin
				summaryOne[POS_POWER_ON] <= 1'b1;
			end else if (clear_faults_command) begin
				summaryOne[POS_POWER_ON] <= 1'b0;
			end else begin
				// No event: hold the flag, so the reset value stays visible
				summaryOne[POS_POWER_ON] <= summaryOne[POS_POWER_ON];
			end
		end
	end

	// Second summary word: memory error, frame fault, thermal zones
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			// Second word resets to all zero
			summaryTwo <= RST_STATUS;
		end else begin
			// Memory error, frame fault and shutdowns stay until a clear
			summaryTwo <= updateWord(summaryTwo, rawTwo, STICKY_TWO, clear_faults_command);
		end
	end

	// Half-bridge words
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			// Both bridge words reset to zero
			bridgeOc <= RST_STATUS;
			bridgeOl <= RST_STATUS;
		end else begin
			// Off-state open load stays live, the rest is held
			bridgeOc <= updateWord(bridgeOc, rawBridgeOc, STICKY_BRIDGE_OC, clear_faults_command);
			bridgeOl <= updateWord(bridgeOl, rawBridgeOl, STICKY_BRIDGE_OL, clear_faults_command);
		end
	end

	// Glass, heater and high-side words
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			// All three words reset to zero
			glassHeat <= RST_STATUS;
			highSide <= RST_STATUS;
			highTrip <= RST_STATUS;
		end else begin
			// Faults held, trip warnings and diagnostic result live
			glassHeat <= updateWord(glassHeat, rawGlassHeat, STICKY_GLASS_HEAT, clear_faults_command);
			highSide <= updateWord(highSide, rawHighSide, STICKY_HIGH_SIDE, clear_faults_command);
			highTrip <= updateWord(highTrip, rawHighTrip, STICKY_HIGH_TRIP, clear_faults_command);
		end
	end

	// Pin edge detection against the previous sample
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			// Idle levels, so that leaving reset gives no false edge
			sclkPrev <= 1'b0;
			csPrev <= 1'b1;
		end else begin
			sclkPrev <= sclk;
			csPrev <= chipSelectN;
		end
	end

	// Frame boundaries and clock edges inside a frame
	always_comb begin
		frameStart = csPrev & ~chipSelectN;
		frameEnd = ~csPrev & chipSelectN;
		sclkRise = (linkState == LINK_FRAME) & ~chipSelectN & sclk & ~sclkPrev;
		sclkFall = (linkState == LINK_FRAME) & ~chipSelectN & ~sclk & sclkPrev;
		countFaultEvent = frameEnd & (linkState == LINK_FRAME) & (bitCount != FRAME_BITS_CNT);
		// Saturate, so that a very long frame cannot wrap back to a good count
		if (sclkFall && bitCount != COUNT_MAX) begin
			next_bitCount = bitCount + 5'h01;
		end else begin
			next_bitCount = bitCount;
		end
	end

	// Frame state
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			linkState <= LINK_IDLE;
		end else begin
			case (linkState)
				// Wait for chip select to fall
				LINK_IDLE: begin
					if (frameStart) begin
						linkState <= LINK_FRAME;
					end
				end
				// Count clocks until chip select rises
				LINK_FRAME: begin
					if (frameEnd) begin
						linkState <= LINK_IDLE;
					end
				end
				default: linkState <= LINK_IDLE;
			endcase
		end
	end

	// Receive side: clock count and command byte sampled on falling edges
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			bitCount <= 5'h00;
			rxCommand <= 8'h00;
		end else if (frameStart) begin
			// A new frame restarts the count
			bitCount <= 5'h00;
			rxCommand <= 8'h00;
		end else begin
			bitCount <= next_bitCount;
			// Only the address byte is kept; write data is dropped
			if (sclkFall && bitCount < ADDR_DONE_CNT) begin
				rxCommand <= {rxCommand[6:0], sdi};
			end
		end
	end

	// Transmit side: status byte first, then the addressed word
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			txShift <= {FRAME_BITS{1'b0}};
			sdo <= 1'b0;
		end else if (frameStart) begin
			// Status byte goes out on the first eight rises
			txShift <= {STATUS_LEAD, anyFault, anyWarn, voltageSum,
				|{bridgeSum, glassSum, highSum}, summaryOne[3],
				~summaryOne[POS_LINK_OK], READ_ZERO};
			sdo <= 1'b0;
		end else if (sclkRise) begin
			// Most significant bit first
			sdo <= txShift[FRAME_BITS-1];
			txShift <= {txShift[FRAME_BITS-2:0], 1'b0};
		end else if (sclkFall && next_bitCount == ADDR_DONE_CNT) begin
			// Address byte complete: load data for reads, zero for writes
			if (rxCommand[READ_FLAG_POS-17]) begin
				txShift[FRAME_BITS-1:8] <= readWord({rxCommand[ADDR_WIDTH-2:0], sdi});
			end else begin
				txShift[FRAME_BITS-1:8] <= READ_ZERO;
			end
		end
	end

	// Output enable follows chip select
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			sdoEn <= 1'b0;
		end else begin
			// Pin released between frames
			sdoEn <= ~chipSelectN;
		end
	end

endmodule
`default_nettype wire

// >>> tb/driver_fault_status_bank_chk.sv
// Checker for the serial output timing of the fault status bank
`timescale 1ns/1ps
`default_nettype none
module driver_fault_status_bank_chk (
	// Clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// Serial link pins
	input wire logic sclk,
	input wire logic chipSelectN,
	input wire logic sdo,
	input wire logic sdoEn
);
	// Last serial clock level
	logic prevSclk;
	// Serial clock rises so far in this frame
	logic [4:0] riseCnt;
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	// Keep the previous serial clock level
	always_ff @(posedge clock) begin
		prevSclk <= sclk;
	end
	// Count rises while selected, restart between frames
	always_ff @(posedge clock) begin
		if (sys_rst || chipSelectN) begin
			riseCnt <= 5'h00;
		end else if (sclk && !prevSclk) begin
			riseCnt <= riseCnt + 5'h01;
		end
	end
	a_reset_quiet: assert property ($fell(sys_rst) |-> !sdoEn && !sdo)
		else $error("serial output active after reset");
	a_enable_on: assert property ($fell(chipSelectN) |=> sdoEn)
		else $error("output not enabled after select");
	a_enable_off: assert property ($rose(chipSelectN) |=> !sdoEn)
		else $error("output still enabled after deselect");
	a_enable_hold: assert property ((!chipSelectN)[*3] |-> sdoEn)
		else $error("output dropped inside a frame");
	a_idle_off: assert property (chipSelectN[*2] |-> !sdoEn)
		else $error("output driven between frames");
	a_sdo_steady: assert property ((!chipSelectN && !sclk)[*5] |-> $stable(sdo))
		else $error("serial output moved without a clock rise");
	a_lead_ones: assert property ($rose(sclk) && !chipSelectN && riseCnt < 5'h02 |-> ##3 sdo)
		else $error("leading response bits not one");
	a_bit_hold: assert property ($rose(sclk) && !chipSelectN |-> ##4 $stable(sdo)[*5])
		else $error("serial output bit not held");
endmodule
bind driver_fault_status_bank driver_fault_status_bank_chk chk (.clock(clock), .sys_rst(sys_rst),
	.sclk(sclk), .chipSelectN(chipSelectN), .sdo(sdo), .sdoEn(sdoEn));
`default_nettype wire

// >>> tb/status_host.sv
// Host controller model that runs frames on the serial link
`timescale 1ns/1ps
`default_nettype none
module status_host (
	// Clock
	input wire logic clock,
	// Frame request
	input wire logic startReq,
	input wire logic writeReq,
	input wire logic [5:0] addrReq,
	input wire logic [15:0] dataReq,
	input wire logic [4:0] pulses,
	// Serial link pins
	input wire logic sdo,
	input wire logic sdoEn,
	output logic sclk,
	output logic chipSelectN,
	output logic sdi,
	// Captured response
	output logic [23:0] resp,
	output logic done
);
	// Outgoing frame word
	logic [23:0] word;
	// Idle link: clock low, deselected
	initial begin
		{sclk, chipSelectN, sdi, resp, done} = {3'b010, 24'h000000, 1'b0};
	end
	// One frame per request, data out on rise, response taken late in the high phase
	always begin
		@(posedge clock);
		done <= 1'b0;
		if (startReq) begin
			word = {1'b0, !writeReq, addrReq, dataReq};
			chipSelectN <= 1'b0;
			repeat (6) @(posedge clock);
			for (int i = 0; i < 24 && i < pulses; i++) begin
				sdi <= word[23 - i];
				sclk <= 1'b1;
				repeat (6) @(posedge clock);
				resp <= {resp[22:0], sdo & sdoEn};
				sclk <= 1'b0;
				repeat (6) @(posedge clock);
			end
			chipSelectN <= 1'b1;
			sdi <= ~sdi;
			done <= 1'b1;
		end
	end
endmodule
`default_nettype wire

// >>> tb/driver_fault_status_bank_bench.sv
// Self-checking bench for the fault status bank
`timescale 1ns/1ps
`default_nettype none
module driver_fault_status_bank_bench;
	import fault_status_pkg::*;
	// Clock, reset and host request
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic clr = 1'b0;
	logic start = 1'b0;
	logic wr = 1'b0;
	logic [5:0] adr = 6'h00;
	logic [15:0] dat = 16'h0000;
	logic [4:0] pul = 5'h18;
	// Detector patterns, held copies of sticky ones, random source
	logic [15:0] rA = 16'h0000, rB = 16'h0000, rC = 16'h0000, rD = 16'h0000, rE = 16'h0000;
	logic [15:0] sA, sB, sC, sE;
	logic [15:0] lf = 16'h0026;
	logic fErr = 1'b0;
	// Link and captured response
	logic sclk, chipSelectN, sdi, sdo, sdoEn, done;
	logic [23:0] resp;
	int fail_count = 0;
	int checks_done = 0;
	typedef struct {logic [5:0] a; logic [23:0] e; logic [23:0] m;} note_t;
	note_t notes[$];
	note_t n;
	logic [5:0] addrs[10] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h07, 6'h08, 6'h3F};
	always #5 clock = ~clock;
	driver_fault_status_bank DUT (.clock(clock), .sys_rst(sys_rst), .sclk(sclk),
		.chipSelectN(chipSelectN), .sdi(sdi), .sdo(sdo), .sdoEn(sdoEn),
		.porDetected(rE[15]), .otpError(rE[14]), .supply_undervoltage(rA[13]),
		.supply_overvoltage_low_level(rA[14]), .supply_overvoltage_high_level(rE[13]),
		.pump_undervoltage(rA[15]), .watchdog_fault(rE[12]), .zone_thermal_shutdown(rB[15:12]),
		.zone_hot_warning(rC[15:12]), .zone_warm_warning(rD[15:12]),
		.bridge_low_overcurrent(rA[5:0]), .bridge_high_overcurrent(rA[11:6]),
		.bridge_offstate_open_load(rA[12]), .bridge_low_active_open_load(rB[5:0]),
		.bridge_high_active_open_load(rB[11:6]), .glass_diag_select(rE[1:0]),
		.glassShortFault(rE[2]), .glassOffOpenLoad(rE[3]), .glass_battery_short(rE[4]),
		.glass_regulation_high(rE[5]), .glass_regulation_low(rE[6]), .glass_overcurrent(rE[7]),
		.glass_open_load(rE[8]), .heater_open_load(rE[9]), .heater_drain_source_fault(rE[10]),
		.glassDischargeTrip(rE[11]), .output_trip_warning(rD[11:0]),
		.high_side_open_load(rC[5:0]), .high_side_overcurrent(rC[11:6]), .clear_faults_command(clr));
	status_host host (.clock(clock), .startReq(start), .writeReq(wr), .addrReq(adr), .dataReq(dat),
		.pulses(pul), .sdo(sdo), .sdoEn(sdoEn), .sclk(sclk), .chipSelectN(chipSelectN), .sdi(sdi),
		.resp(resp), .done(done));
	// Bench copy of held bits; a set in the clear cycle wins, power-on starts set
	always @(posedge clock) begin
		if (sys_rst) begin
			{sA, sB, sC, sE} <= {48'h0, 16'h8000};
		end else begin
			sA <= (clr ? 16'h0000 : sA) | (rA & 16'hEFFF);
			sB <= (clr ? 16'h0000 : sB) | rB;
			sC <= (clr ? 16'h0000 : sC) | (rC & 16'h0FFF);
			sE <= (clr ? 16'h0000 : sE) | (rE & 16'hFFF0);
		end
	end
	// Next random word
	function automatic logic [15:0] rnd();
		lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
		return lf;
	endfunction
	// Expected register word from the detector state
	function automatic logic [15:0] ex(input logic [5:0] a);
		logic [15:0] A, B, C, E, w;
		{A, B, C, E, w} = {rA | sA, rB | sB, rC | sC, rE | sE, 16'h0000};
		case (a)
			6'h00: begin
				w[10:8] = {|{A[11:0], B[11:0]}, |E[10:4], |C[11:0]};
				w[7:4] = {A[13], A[14], A[15], |{C[15:12], rD[15:12]}};
				// Trip bit follows the pins; the held discharge flag still warns
				w[3:0] = {|B[15:12], E[12], |{rD[11:0], rE[11]}, E[13]};
				w[13] = |{w[10:5], w[3:2], w[0], E[14], fErr};
				w[12] = |{w[4], w[1], E[11]};
				w[15:14] = {!fErr, E[15]};
			end
			6'h01: w = {E[14], 1'b0, fErr, 1'b0, B[15:12], C[15:12], rD[15:12]};
			6'h03: w = {2'h0, A[5:0], 2'h0, A[11:6]};
			6'h04: w = {3'h0, A[12], B[5:0], B[11:6]};
			6'h05: w = {(E[1:0] == 2'h1) ? E[2] : (E[1:0] == 2'h2) && E[3], E[4], E[5], E[6],
				E[7], E[8], E[9], E[10], 1'b0, rD[6:0]};
			6'h06: w = {2'h0, C[5:0], 2'h0, C[11:6]};
			6'h07: w = {9'h000, E[11], 1'b0, rD[11:7]};
			default: w = 16'h0000;
		endcase
		return w;
	endfunction
	// Note the expectation, then run one frame and wait for it
	task automatic frame(input logic w, input logic [5:0] a, input logic [15:0] d,
		input logic [4:0] p, input logic [23:0] e, input logic [23:0] m);
		notes.push_back('{a, e, m});
		@(negedge clock);
		{wr, adr, dat, pul, start} = {w, a, d, p, 1'b1};
		@(negedge clock);
		start = 1'b0;
		for (int k = 0; k < 800 && done !== 1'b1; k++) @(negedge clock);
		if (done !== 1'b1) begin
			fail_count++;
			$display("[FAIL] frame end: expected 1 seen %b", done);
		end
		repeat (2) @(negedge clock);
	endtask
	// Expected status byte sent ahead of every read word
	function automatic logic [7:0] stat();
		logic [15:0] w;
		w = ex(6'h00);
		return {2'b11, w[13], w[12], |{w[7:5], w[0]}, |w[10:8], w[3], !w[15]};
	endfunction
	// Read one register, comparing the status byte and the bits under the mask
	task automatic rd(input logic [5:0] a, input logic [15:0] m);
		frame(1'b0, a, 16'h0000, 5'h18, {stat(), ex(a) & m}, {8'hFF, m});
	endtask
	// One-cycle clear-fault pulse
	task automatic clear_all();
		@(negedge clock);
		clr = 1'b1;
		@(negedge clock);
		clr = 1'b0;
		fErr = 1'b0;
		repeat (4) @(negedge clock);
	endtask
	// Print the verdict and end the run
	task automatic report_and_stop();
		if (fail_count == 0 && checks_done > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// Compare each finished frame with the oldest note
	always @(posedge clock) begin
		if (done === 1'b1 && notes.size() > 0) begin
			n = notes.pop_front();
			checks_done++;
			if ((resp & n.m) !== n.e) begin
				fail_count++;
				$display("[FAIL] read of %h: expected %h seen %h", n.a, n.e, resp & n.m);
			end
		end
	end
	// Main sequence
	initial begin
		repeat (10) @(negedge clock);
		sys_rst = 1'b0;
		repeat (2) @(negedge clock);
		foreach (addrs[i]) rd(addrs[i], 16'hFFFF);
		frame(1'b1, 6'h06, 16'hFFFF, 5'h18, 24'hC00000, 24'hC0FFFF);
		rd(6'h06, 16'hFFFF);
		frame(1'b0, 6'h00, 16'h0000, 5'h17, 24'h600000, 24'h600000);
		fErr = 1'b1;
		rd(6'h01, 16'hFFFF);
		rd(6'h00, 16'hC000);
		clear_all();
		rd(6'h00, 16'hFFFF);
		@(negedge clock);
		{rA, rD, rE} = {16'h0001, 16'h0001, 16'h0800};
		@(negedge clock);
		{rA, rD, rE} = 48'h0;
		repeat (4) @(negedge clock);
		foreach (addrs[i]) rd(addrs[i], 16'hFFFF);
		clear_all();
		rd(6'h07, 16'hFFFF);
		for (int j = 0; j < 12; j++) begin
			clear_all();
			{rA, rB, rC, rD} = {rnd() & rnd(), rnd() & rnd(), rnd() & rnd(), rnd() & rnd()};
			rE = (rnd() & rnd() & 16'hFFFC) | {14'h0000, j[1:0]};
			repeat (4) @(negedge clock);
			foreach (addrs[i]) rd(addrs[i], 16'hFFFF);
		end
		report_and_stop();
	end
	// Watchdog against a hung link
	initial begin
		#1000000;
		fail_count++;
		report_and_stop();
	end
endmodule
`default_nettype wire
